// ---- logic/led_ctrl_pkg.sv ----
// Shared constants for the LED driver serial register port and mode control.
// Assumes a 40 MHz system clock; the serial link clock is a separate domain.
package led_ctrl_pkg;

    // System clock rate
    localparam int unsigned SYS_CLK_HZ        = 40_000_000;

    // Trim load and oscillator start times, in nanoseconds
    localparam int unsigned TRIM_LOAD_NS      = 200_000;
    localparam int unsigned OSC_START_NS      = 200_000;
    localparam int unsigned TRIM_LOAD_CYCLES  = (TRIM_LOAD_NS / 1000) * (SYS_CLK_HZ / 1_000_000);
    localparam int unsigned OSC_START_CYCLES  = (OSC_START_NS / 1000) * (SYS_CLK_HZ / 1_000_000);

    // Largest link clock rate the port supports
    localparam int unsigned LINK_MAX_HZ       = 400_000;

    // Slave address layout
    localparam logic [4:0] SLAVE_ADDR_HI      = 5'h0E;
    localparam logic [1:0] STRAP_SUPPLY_LO    = 2'h3;
    localparam logic [1:0] STRAP_GROUND_LO    = 2'h2;
    localparam logic [1:0] STRAP_CLOCK_LO     = 2'h0;
    localparam logic [1:0] STRAP_DATA_LO      = 2'h1;

    // Strap pin sources
    localparam logic [1:0] STRAP_SRC_GROUND   = 2'h0;
    localparam logic [1:0] STRAP_SRC_SUPPLY   = 2'h1;
    localparam logic [1:0] STRAP_SRC_CLOCK    = 2'h2;
    localparam logic [1:0] STRAP_SRC_DATA     = 2'h3;

    // Register offsets in page0
    localparam logic [7:0] SLEEP_CONTROL_OFS  = 8'h01;
    localparam logic [7:0] SOFT_RESET_OFS     = 8'h02;
    localparam logic [7:0] PAGE_SELECT_OFS    = 8'h00;

    // Register values and reset values
    localparam logic [7:0] SLEEP_ENTER_VAL    = 8'h80;
    localparam logic [7:0] SLEEP_EXIT_VAL     = 8'h00;
    localparam logic [7:0] SLEEP_RESET_VAL    = 8'h80;
    localparam logic [7:0] SOFT_RESET_VAL     = 8'h01;
    localparam logic [7:0] PAGE_RESET_VAL     = 8'h00;
    localparam int unsigned SLEEP_BIT         = 7;

    // Register memory geometry: 6 pages of 256 bytes
    localparam int unsigned PAGE_COUNT        = 6;
    localparam int unsigned MEM_ADDR_W        = 11;
    localparam logic [2:0] PAGE_LAST          = 3'h5;

    // Operating modes
    typedef enum logic [2:0] {
        MODE_SHUTDOWN = 3'b000,
        MODE_TRIM     = 3'b001,
        MODE_STANDBY  = 3'b010,
        MODE_WAKING   = 3'b011,
        MODE_ACTIVE   = 3'b100
    } op_mode_e;

endpackage

// ---- logic/led_i2c_mode_ctrl.sv ----
// Serial register port and operating-mode control of a matrix LED driver.
// Assumes SCL/SDA arrive open drain; the serial engine runs on SCL itself.
//
// What this block does
// RULE1: Power-on reset returns all control state and registers to defaults.
// RULE2: After enable rises, wait 200us of trim loading before standby.
// RULE3: After sleep clears, wait 200us before pages one to five open.
// RULE4: Enable low holds shutdown with every register held in reset.
// RULE5: Standby entered on enable rise, or writing 0x80 to sleep register 0x01.
// RULE6: Standby keeps the oscillator stopped; no internal clock runs.
// RULE7: In standby the port works but only page0 is reachable.
// RULE8: Writing 0x00 to sleep register in standby enters active mode.
// RULE9: Writing 0x01 to soft reset register 0x02 resets everything.
// RULE10: Slave only; the master keeps the clock at or below 400kHz.
// RULE11: First byte after start is 7-bit address plus direction bit.
// RULE12: Address is 01110 plus two bits chosen by the strap pin.
// RULE13: SDA falling while SCL high is a start.
// RULE14: SDA rising while SCL high is a stop.
// RULE15: SDA moving during SCL high mid-transfer aborts the transfer.
// RULE16: Bytes are 8 bits, MSB first, followed by an acknowledge.
// RULE17: The master releases SDA after each byte for the slave acknowledge.
// RULE18: The address byte is acknowledged only on an exact match.
// RULE19: Write: register address byte, then data bytes stored with address increment.
// RULE20: Reads start by writing the register address, then restart as reader.
// RULE21: Read: master acknowledge advances and sends next; no acknowledge stops sending.
// RULE22: On an address mismatch, release SDA and ignore all until next start.
// RULE23: Writes to closed pages are discarded without changing stored values.
`timescale 1ns/1ps
module led_i2c_mode_ctrl
    import led_ctrl_pkg::*;
(
    // System clock and power-on reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rstn,
    // Hardware enable and address strap
    input  wire logic       i_hw_enable_pin,
    input  wire logic [1:0] i_addr_strap,
    // Serial link
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda,
    output logic            o_sda_oe,
    // Mode status
    output logic            o_osc_run,
    output logic            o_pages_open,
    output logic [2:0]      o_mode
);

    // Synchronised enable pin, raw SDA sample and link-side copies of system state
    logic hw_enable_pin_sync;
    logic sda_s;
    logic pages_open_link;
    logic clear_link;
    logic link_rstn;

    op_mode_e mode_reg;
    logic [12:0] wait_cnt_reg;
    logic        dev_clear_reg;

    // Link engine state
    typedef enum logic [2:0] {
        LK_IDLE  = 3'b000,
        LK_ADDR  = 3'b001,
        LK_REG   = 3'b010,
        LK_WDATA = 3'b011,
        LK_RDATA = 3'b100,
        LK_RACK  = 3'b101
    } link_state_e;
    link_state_e lk_state_reg;
    logic [7:0]  shift_reg;
    logic [3:0]  bit_cnt_reg;
    logic [7:0]  reg_addr_reg;
    logic [2:0]  page_reg;
    logic        ack_drive_reg;
    logic        start_tog_reg;
    logic        stop_tog_reg;

    // Write event to the system side: toggle plus stable data
    logic        wr_tog_reg;
    logic [7:0]  wr_addr_hold_reg;
    logic [7:0]  wr_data_hold_reg;
    logic [2:0]  wr_page_hold_reg;
    logic        wr_tog_s;
    logic        wr_tog_d_reg;

    // Address decode of the strapped slave address
    function automatic logic [6:0] own_address(input logic [1:0] src);
        logic [1:0] lo;
        lo = STRAP_GROUND_LO;
        unique case (src)
            STRAP_SRC_GROUND: lo = STRAP_GROUND_LO;
            STRAP_SRC_SUPPLY: lo = STRAP_SUPPLY_LO;
            STRAP_SRC_CLOCK:  lo = STRAP_CLOCK_LO;
            STRAP_SRC_DATA:   lo = STRAP_DATA_LO;
        endcase
        return {SLAVE_ADDR_HI, lo};                                    // [RULE12]
    endfunction

    // Enable pin and write toggle synchronisers on the system clock
    led_sync2 u_sync_hw_enable_pin (
        .i_clk   (i_clk_sys),
        .i_rstn  (i_rstn),
        .i_async (i_hw_enable_pin),
        .o_sync  (hw_enable_pin_sync)
    );

    led_sync2 u_sync_wr (
        .i_clk   (i_clk_sys),
        .i_rstn  (i_rstn),
        .i_async (wr_tog_reg),
        .o_sync  (wr_tog_s)
    );

    // Page gate and clear crossing into the link domain (SCL clocks it)
    led_sync2 u_sync_open (
        .i_clk   (i_scl),
        .i_rstn  (i_rstn),
        .i_async (o_pages_open),
        .o_sync  (pages_open_link)
    );

    led_sync2 u_sync_clr (
        .i_clk   (i_scl),
        .i_rstn  (i_rstn),
        .i_async (dev_clear_reg),
        .o_sync  (clear_link)
    );

    // SCL may stop at any time, so the clear also resets the link asynchronously
    assign link_rstn = i_rstn && !dev_clear_reg;                       // [RULE4] [RULE9]

    // Strap re-sampled on every system clock after reset release; a strap tied to SCL or SDA reads its own code
    logic [6:0] own_addr_reg;
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            own_addr_reg <= {SLAVE_ADDR_HI, STRAP_GROUND_LO};
        else
            own_addr_reg <= own_address(i_addr_strap);                 // [RULE12]
    end

    // Sleep and soft reset decode of a crossed write
    logic wr_evt;
    logic wr_page0;
    assign wr_evt   = wr_tog_s ^ wr_tog_d_reg;
    assign wr_page0 = (wr_page_hold_reg == 3'h0);

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            wr_tog_d_reg <= 1'b0;
        else
            wr_tog_d_reg <= wr_tog_s;
    end

    // Operating mode machine
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)                                                   // [RULE1]
        begin
            mode_reg      <= MODE_SHUTDOWN;
            wait_cnt_reg  <= '0;
            dev_clear_reg <= 1'b1;
        end
        else if (!hw_enable_pin_sync)                                           // [RULE4]
        begin
            mode_reg      <= MODE_SHUTDOWN;
            wait_cnt_reg  <= '0;
            dev_clear_reg <= 1'b1;
        end
        else if (wr_evt && wr_page0 && wr_addr_hold_reg == SOFT_RESET_OFS
                 && wr_data_hold_reg == SOFT_RESET_VAL)                // [RULE9]
        begin
            mode_reg      <= MODE_STANDBY;
            wait_cnt_reg  <= '0;
            dev_clear_reg <= 1'b1;
        end
        else
        begin
            dev_clear_reg <= 1'b0;
            unique case (mode_reg)
                MODE_SHUTDOWN:
                begin
                    mode_reg     <= MODE_TRIM;
                    wait_cnt_reg <= 13'(TRIM_LOAD_CYCLES - 1);         // [RULE2]
                end
                MODE_TRIM:
                begin
                    if (wait_cnt_reg == '0)
                        mode_reg <= MODE_STANDBY;                      // [RULE5]
                    else
                        wait_cnt_reg <= wait_cnt_reg - 1'b1;
                end
                MODE_STANDBY:
                begin
                    if (wr_evt && wr_page0 && wr_addr_hold_reg == SLEEP_CONTROL_OFS
                        && wr_data_hold_reg == SLEEP_EXIT_VAL)         // [RULE8]
                    begin
                        mode_reg     <= MODE_WAKING;
                        wait_cnt_reg <= 13'(OSC_START_CYCLES - 1);     // [RULE3]
                    end
                end
                MODE_WAKING:
                begin
                    if (wr_evt && wr_page0 && wr_addr_hold_reg == SLEEP_CONTROL_OFS
                        && wr_data_hold_reg[SLEEP_BIT])
                        mode_reg <= MODE_STANDBY;
                    else if (wait_cnt_reg == '0)
                        mode_reg <= MODE_ACTIVE;                       // [RULE3]
                    else
                        wait_cnt_reg <= wait_cnt_reg - 1'b1;
                end
                MODE_ACTIVE:
                begin
                    if (wr_evt && wr_page0 && wr_addr_hold_reg == SLEEP_CONTROL_OFS
                        && wr_data_hold_reg == SLEEP_ENTER_VAL)        // [RULE5]
                        mode_reg <= MODE_STANDBY;
                end
                default:
                    mode_reg <= MODE_SHUTDOWN;
            endcase
        end
    end

    // Status outputs, registered
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_osc_run    <= 1'b0;
            o_pages_open <= 1'b0;
            o_mode       <= MODE_SHUTDOWN;
        end
        else
        begin
            o_osc_run    <= (mode_reg == MODE_WAKING) || (mode_reg == MODE_ACTIVE); // [RULE6]
            o_pages_open <= (mode_reg == MODE_ACTIVE) && (wait_cnt_reg == '0);     // [RULE7]
            o_mode       <= mode_reg;
        end
    end

    // Memory for all pages; written from the link domain data once it is stable
    logic [7:0] rd_data;
    logic       mem_wr;
    assign mem_wr = wr_evt && !dev_clear_reg && mode_reg != MODE_SHUTDOWN;

    led_reg_mem u_mem (
        .i_clk_sys (i_clk_sys),
        .i_clear   (dev_clear_reg),
        .i_wr_en   (mem_wr),
        .i_wr_addr ({wr_page_hold_reg, wr_addr_hold_reg}),
        .i_wr_data (wr_data_hold_reg),
        .i_rd_addr ({page_reg, reg_addr_reg + 8'(lk_state_reg == LK_RACK)}),
        .o_rd_data (rd_data)
    );

    // Start and stop detection: SDA edges while SCL high
    always_ff @(negedge i_sda or negedge link_rstn)
    begin
        if (!link_rstn)
            start_tog_reg <= 1'b0;
        else if (i_scl)
            start_tog_reg <= ~start_tog_reg;                           // [RULE13]
    end

    always_ff @(posedge i_sda or negedge link_rstn)
    begin
        if (!link_rstn)
            stop_tog_reg <= 1'b0;
        else if (i_scl)
            stop_tog_reg <= ~stop_tog_reg;                             // [RULE14] [RULE15]
    end

    // Condition seen since the last SCL rise
    logic start_seen_reg;
    logic stop_seen_reg;
    logic start_ref_reg;
    logic stop_ref_reg;
    logic got_start;
    logic got_stop;
    assign got_start = start_tog_reg ^ start_ref_reg;
    assign got_stop  = stop_tog_reg ^ stop_ref_reg;
    assign sda_s     = i_sda;

    // Link engine on SCL rise: sample data, advance state
    always_ff @(posedge i_scl or negedge link_rstn)
    begin
        if (!link_rstn)
        begin
            lk_state_reg  <= LK_IDLE;
            shift_reg     <= 8'h00;
            bit_cnt_reg   <= 4'h0;
            reg_addr_reg  <= 8'h00;
            page_reg      <= 3'h0;
            wr_tog_reg    <= 1'b0;
            wr_addr_hold_reg <= 8'h00;
            wr_data_hold_reg <= 8'h00;
            wr_page_hold_reg <= 3'h0;
            start_ref_reg <= 1'b0;
            stop_ref_reg  <= 1'b0;
        end
        else
        begin
            start_ref_reg <= start_tog_reg;
            stop_ref_reg  <= stop_tog_reg;
            if (got_start)                                             // [RULE11]
            begin
                lk_state_reg <= LK_ADDR;
                shift_reg    <= {7'h00, sda_s};
                bit_cnt_reg  <= 4'h1;
            end
            else if (got_stop)                                         // [RULE15] [RULE22]
                lk_state_reg <= LK_IDLE;
            else if (lk_state_reg != LK_IDLE)
            begin
                if (bit_cnt_reg == 4'h8)
                begin
                    // Ninth clock: acknowledge slot, byte is complete
                    bit_cnt_reg <= 4'h0;
                    unique case (lk_state_reg)
                        LK_ADDR:
                            if (shift_reg[7:1] != own_addr_reg)
                                lk_state_reg <= LK_IDLE;               // [RULE18] [RULE22]
                            else if (shift_reg[0])
                                lk_state_reg <= LK_RDATA;              // [RULE20]
                            else
                                lk_state_reg <= LK_REG;
                        LK_REG:
                        begin
                            reg_addr_reg <= shift_reg;                 // [RULE19]
                            lk_state_reg <= LK_WDATA;
                        end
                        LK_WDATA:
                        begin
                            if (page_reg == 3'h0 || pages_open_link)   // [RULE23]
                            begin
                                wr_addr_hold_reg <= reg_addr_reg;
                                wr_data_hold_reg <= shift_reg;
                                wr_page_hold_reg <= page_reg;
                                wr_tog_reg       <= ~wr_tog_reg;
                                if (page_reg == 3'h0 && reg_addr_reg == PAGE_SELECT_OFS
                                    && shift_reg[2:0] <= PAGE_LAST)
                                    page_reg <= shift_reg[2:0];
                            end
                            reg_addr_reg <= reg_addr_reg + 1'b1;       // [RULE19]
                        end
                        LK_RACK:
                            if (sda_s)
                                lk_state_reg <= LK_IDLE;               // [RULE21]
                            else
                            begin
                                reg_addr_reg <= reg_addr_reg + 1'b1;   // [RULE21]
                                lk_state_reg <= LK_RDATA;
                            end
                        default:
                            lk_state_reg <= LK_IDLE;
                    endcase
                end
                else
                begin
                    shift_reg   <= {shift_reg[6:0], sda_s};            // [RULE16]
                    bit_cnt_reg <= bit_cnt_reg + 1'b1;
                    if (lk_state_reg == LK_RDATA && bit_cnt_reg == 4'h7)
                        lk_state_reg <= LK_RACK;
                end
            end
        end
    end

    // SDA drive on SCL fall: acknowledge or read data, released otherwise
    logic [7:0] tx_reg;
    always_ff @(negedge i_scl or negedge link_rstn)
    begin
        if (!link_rstn)
        begin
            ack_drive_reg <= 1'b0;
            tx_reg        <= 8'h00;
        end
        else if (bit_cnt_reg == 4'h8 && lk_state_reg != LK_RACK
                 && lk_state_reg != LK_RDATA
                 && !(lk_state_reg == LK_ADDR && shift_reg[7:1] != own_addr_reg))
            ack_drive_reg <= 1'b1;                                     // [RULE17] [RULE18]
        else if (lk_state_reg == LK_RDATA && bit_cnt_reg == 4'h0)
        begin
            tx_reg        <= (page_reg == 3'h0 || pages_open_link) ? rd_data : 8'h00;
            ack_drive_reg <= ~rd_data[7];
        end
        else if (lk_state_reg == LK_RDATA || lk_state_reg == LK_RACK && bit_cnt_reg != 4'h0)
        begin
            tx_reg        <= {tx_reg[6:0], 1'b0};
            ack_drive_reg <= ~tx_reg[6] && lk_state_reg == LK_RDATA;   // [RULE16]
        end
        else
            ack_drive_reg <= 1'b0;
    end

    // Open-drain pin: only ever pulls low
    assign o_sda    = 1'b0;
    assign o_sda_oe = ack_drive_reg;                                   // [RULE10]

endmodule

// ---- logic/led_reg_mem.sv ----
// Register storage for pages 0 to 5, page0 special-function bytes such as sleep control included.
// Assumes at most one write and one read per system clock; read data is registered.
`timescale 1ns/1ps
module led_reg_mem
    import led_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_clear,
    // Write side
    input  wire logic                  i_wr_en,
    input  wire logic [MEM_ADDR_W-1:0] i_wr_addr,
    input  wire logic [7:0]            i_wr_data,
    // Read side
    input  wire logic [MEM_ADDR_W-1:0] i_rd_addr,
    output logic      [7:0]            o_rd_data
);

    logic [7:0] mem_reg [0:(1<<MEM_ADDR_W)-1];
    logic [MEM_ADDR_W:0] clr_ptr_reg;

    // Clear walks the array once; writes during the walk are dropped so no stale byte survives
    always_ff @(posedge i_clk_sys)
    begin
        if (i_clear)
            clr_ptr_reg <= '0;
        else if (!clr_ptr_reg[MEM_ADDR_W])
            clr_ptr_reg <= clr_ptr_reg + 1'b1;
    end

    // Storage array; no reset so it maps to a RAM
    always_ff @(posedge i_clk_sys)
    begin
        if (!clr_ptr_reg[MEM_ADDR_W])
            mem_reg[clr_ptr_reg[MEM_ADDR_W-1:0]] <= (clr_ptr_reg[MEM_ADDR_W-1:0] == {3'h0, SLEEP_CONTROL_OFS}) ? SLEEP_RESET_VAL : 8'h00;
        else if (i_wr_en)
            mem_reg[i_wr_addr] <= i_wr_data;
    end

    // Registered read port
    always_ff @(posedge i_clk_sys)
    begin
        o_rd_data <= mem_reg[i_rd_addr];
    end

endmodule

// ---- logic/led_sync2.sv ----
// Two flip-flop level synchroniser.
// Assumes the input is asynchronous to the destination clock.
`timescale 1ns/1ps
module led_sync2
(
    // Destination clock and reset
    input  wire logic i_clk,
    input  wire logic i_rstn,
    // Level in and out
    input  wire logic i_async,
    output logic      o_sync
);

    logic meta_reg;

    // The first stage feeds only the second
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            meta_reg <= 1'b0;
            o_sync   <= 1'b0;
        end
        else
        begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end

endmodule

// ---- tb/i2c_master_model.sv ----
// Behavioural serial bus master on the far side of the port.
// Assumes a pull-up on SDA; this model only pulls low or releases.
`timescale 1ns/1ps
module i2c_master_model
(
    // Link clock and data pull-down
    output logic      o_scl,
    output logic      o_sda_oe,
    // Resolved data line
    input  wire logic i_sda
);
    // Idle: clock stands high, data released
    initial
    begin
        o_scl    = 1'b1;
        o_sda_oe = 1'b0;
    end

    // One 32 ns bit; data moves only while the clock is low
    task automatic bit_io(input logic b, output logic r);
        o_sda_oe = !b;
        #8 o_scl = 1'b1;
        #8 r = i_sda;
        #8 o_scl = 1'b0;
        #8;
    endtask

    // Start or repeated start
    task automatic start();
        o_sda_oe = 1'b0;
        #8 o_scl = 1'b1;
        #16 o_sda_oe = 1'b1;
        #16 o_scl = 1'b0;
        #8;
    endtask

    // Stop, leaving the clock high
    task automatic stop();
        o_sda_oe = 1'b1;
        #8 o_scl = 1'b1;
        #16 o_sda_oe = 1'b0;
        #16;
    endtask

    // Byte out MSB first, then data released for the acknowledge
    task automatic put(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask

    // Byte in, then acknowledge or not
    task automatic get(input logic ack_it, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            b[i] = r;
        end
        bit_io(!ack_it, r);
    endtask
endmodule

// ---- tb/led_i2c_mode_ctrl_properties.sv ----
// Port assertions for the serial port and mode control.
// Assumes the package mode codes; bound to every instance.
`timescale 1ns/1ps
module led_i2c_mode_ctrl_properties
    import led_ctrl_pkg::*;
(
    // Clock, reset and enable
    input wire logic       i_clk_sys,
    input wire logic       i_rstn,
    input wire logic       i_hw_enable_pin,
    // Watched outputs
    input wire logic       o_osc_run,
    input wire logic       o_pages_open,
    input wire logic [2:0] o_mode
);
    int unsigned dwell;
    logic [2:0]  prev_mode;

    default clocking dc @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    // Cycles spent in a mode; a wait off by more than 2 shows up here
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            dwell     <= 0;
            prev_mode <= 3'h0;
        end
        else
        begin
            dwell     <= (o_mode == prev_mode) ? dwell + 1 : 0;
            prev_mode <= o_mode;
        end
    end

    a_shutdown_hold: assert property ((!i_hw_enable_pin) [*5] |->
        o_mode == MODE_SHUTDOWN && !o_osc_run && !o_pages_open) else $error("not shut down");
    a_osc_follows: assert property ($stable(o_mode) |->
        o_osc_run == (o_mode inside {MODE_WAKING, MODE_ACTIVE})) else $error("osc wrong");
    a_pages_closed: assert property ((o_mode != MODE_ACTIVE) [*2] |->
        !o_pages_open) else $error("pages open outside active");
    a_trim_time: assert property (prev_mode == MODE_TRIM && o_mode == MODE_STANDBY |->
        dwell + 2 >= TRIM_LOAD_CYCLES && dwell <= TRIM_LOAD_CYCLES + 2) else $error("trim time");
    a_wake_time: assert property (prev_mode == MODE_WAKING && o_mode == MODE_ACTIVE |->
        dwell + 2 >= OSC_START_CYCLES && dwell <= OSC_START_CYCLES + 2) else $error("wake time");
    a_pages_prompt: assert property (prev_mode == MODE_WAKING && o_mode == MODE_ACTIVE |->
        ##[0:4] o_pages_open) else $error("pages late");
    a_enable_exit: assert property (prev_mode == MODE_SHUTDOWN && o_mode != MODE_SHUTDOWN |->
        o_mode == MODE_TRIM) else $error("shutdown exit");
    a_waking_entry: assert property (o_mode == MODE_WAKING && prev_mode != MODE_WAKING |->
        prev_mode == MODE_STANDBY) else $error("waking entry");

    // Main scenarios reached
    cover property (prev_mode == MODE_WAKING && o_mode == MODE_ACTIVE);
    cover property (prev_mode == MODE_ACTIVE && o_mode == MODE_STANDBY);
    cover property ($rose(o_pages_open));
endmodule

bind led_i2c_mode_ctrl led_i2c_mode_ctrl_properties props (.i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn), .i_hw_enable_pin(i_hw_enable_pin), .o_osc_run(o_osc_run),
    .o_pages_open(o_pages_open), .o_mode(o_mode));

// ---- tb/test_led_i2c_mode_ctrl.sv ----
// Self-checking bench driving the port through the master model.
// Assumes SDA is pulled up; the wire is resolved here.
`timescale 1ns/1ps
module test_led_i2c_mode_ctrl
    import led_ctrl_pkg::*;
;
    localparam logic [6:0] dev_addr = {SLAVE_ADDR_HI, STRAP_GROUND_LO};
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       en = 1'b0;
    logic [1:0] strap = STRAP_SRC_GROUND;
    logic       scl, m_oe, d_oe, d_sda, osc, pages, ack;
    logic [2:0] mode;
    logic [7:0] r0, r1;
    int         mismatches = 0;
    int         n_compared = 0;
    logic [1:0] lo [4] = '{STRAP_GROUND_LO, STRAP_SUPPLY_LO, STRAP_CLOCK_LO, STRAP_DATA_LO};
    // Low if either side pulls
    wire        sda = !m_oe && (!d_oe || d_sda);

    // 40 MHz system clock
    always #12.5 clk = !clk;

    led_i2c_mode_ctrl dut (.i_clk_sys(clk), .i_rstn(rstn), .i_hw_enable_pin(en),
        .i_addr_strap(strap), .i_scl(scl), .i_sda(sda), .o_sda(d_sda), .o_sda_oe(d_oe),
        .o_osc_run(osc), .o_pages_open(pages), .o_mode(mode));
    i2c_master_model m (.o_scl(scl), .o_sda_oe(m_oe), .i_sda(sda));

    task automatic stop_test();
        $display("mismatches=%0d compared=%0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_f(input logic got, input logic exp);
        chk({7'h0, got}, {7'h0, exp});
    endtask

    // Bounded wait for a mode; giving up ends the run
    task automatic wait_mode(input logic [2:0] exp);
        for (int n = 0; n < 9000 && mode !== exp; n++)
            @(negedge clk);
        chk({5'h0, mode}, {5'h0, exp});
        if (mode !== exp)
            stop_test();
    endtask

    task automatic wr(input logic [7:0] ra, input logic [7:0] d0, input logic [7:0] d1,
                      input int n);
        logic [7:0] b [4];
        b = '{{dev_addr, 1'b0}, ra, d0, d1};
        m.start();
        for (int i = 0; i < n + 2; i++)
        begin
            m.put(b[i], ack);
            chk_f(ack, 1'b1);
        end
        m.stop();
    endtask

    task automatic rd(input logic [7:0] ra);
        m.start();
        m.put({dev_addr, 1'b0}, ack);
        m.put(ra, ack);
        m.start();
        m.put({dev_addr, 1'b1}, ack);
        chk_f(ack, 1'b1);
        m.get(1'b1, r0);
        m.get(1'b0, r1);
        chk_f(d_oe, 1'b0);
        m.stop();
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        wait_mode(MODE_SHUTDOWN);
        @(posedge clk);
        en <= 1'b1;
        wait_mode(MODE_TRIM);
        wait_mode(MODE_STANDBY);
        chk_f(osc, 1'b0);
        // Every strap, matching and neighbouring address
        for (int s = 0; s < 4; s++)
        begin
            @(posedge clk);
            strap <= s[1:0];
            repeat (4) @(posedge clk);
            for (int w = 0; w < 2; w++)
            begin
                m.start();
                m.put({SLAVE_ADDR_HI, lo[s] ^ w[1:0], 1'b0}, ack);
                chk_f(ack, w == 0);
                m.stop();
            end
        end
        @(posedge clk);
        strap <= STRAP_SRC_GROUND;
        repeat (4) @(posedge clk);
        rd(SLEEP_CONTROL_OFS);
        chk(r0, SLEEP_RESET_VAL);
        wr(SLEEP_CONTROL_OFS, SLEEP_EXIT_VAL, 8'h00, 1);
        wait_mode(MODE_WAKING);
        chk_f(osc, 1'b1);
        chk_f(pages, 1'b0);
        wr(PAGE_SELECT_OFS, 8'h01, 8'h00, 1);
        wr(8'h10, 8'h77, 8'h00, 1);
        wait_mode(MODE_ACTIVE);
        repeat (5) @(negedge clk);
        chk_f(pages, 1'b1);
        rd(8'h10);
        chk(r0, 8'h00);
        wr(8'h10, 8'hA5, 8'h5A, 2);
        rd(8'h10);
        chk(r0, 8'hA5);
        chk(r1, 8'h5A);
        @(posedge clk);
        en <= 1'b0;
        wait_mode(MODE_SHUTDOWN);
        @(posedge clk);
        en <= 1'b1;
        wait_mode(MODE_STANDBY);
        wr(SLEEP_CONTROL_OFS, SLEEP_EXIT_VAL, 8'h00, 1);
        wait_mode(MODE_ACTIVE);
        wr(SLEEP_CONTROL_OFS, SLEEP_ENTER_VAL, 8'h00, 1);
        wait_mode(MODE_STANDBY);
        wr(SLEEP_CONTROL_OFS, SLEEP_EXIT_VAL, 8'h00, 1);
        wait_mode(MODE_WAKING);
        wr(SOFT_RESET_OFS, SOFT_RESET_VAL, 8'h00, 1);
        wait_mode(MODE_STANDBY);
        rd(SLEEP_CONTROL_OFS);
        chk(r0, SLEEP_RESET_VAL);
        stop_test();
    end
endmodule
